// ===== rtl/asr_pkg.sv
// package: register map, field positions, reset values and shared types of the serial receiver
package asr_pkg;

  // register byte offsets on the register bus
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_BAUD = 4'hC;

  // control register bit positions
  localparam int CTL_RX_EN = 0;
  localparam int CTL_RIE = 1;
  localparam int CTL_ID_WAIT = 2;
  localparam int CTL_SEVEN = 3;
  localparam int CTL_PAR_EN = 4;
  localparam int CTL_PAR_ODD = 5;
  localparam int CTL_ADDR_FMT = 6;
  localparam int CTL_TWO_STOP = 7;
  localparam int CTL_TX_ADDR = 8;

  // status register bit positions
  localparam int STS_FULL = 0;
  localparam int STS_OVR = 1;
  localparam int STS_FER = 2;
  localparam int STS_PER = 3;
  localparam int STS_ADDR_BIT = 4;
  localparam int STS_LINE = 5;

  // sampling: 16 base ticks per bit, latch on the 8th
  localparam logic [3:0] TICKS_LAST = 4'hF;
  localparam logic [3:0] MID_START = 4'h7;
  localparam logic [2:0] BITS_8_LAST = 3'h7;
  localparam logic [2:0] BITS_7_LAST = 3'h6;

  // reset value of the base-tick divisor (tick period is divisor + 1 clocks)
  localparam logic [15:0] BAUD_RESET = 16'h00A2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic tx_address_bit;
    logic two_stop;
    logic address_bit_format;
    logic parity_odd;
    logic parity_enable;
    logic seven_bit_select;
    logic id_wait_enable;
    logic receive_irq_enable;
    logic rx_enable;
  } asr_ctrl_t;

  typedef struct packed {
    logic level;
    logic tick;
  } asr_line_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_EXTRA,
    RX_STOP
  } asr_rx_state_t;

endpackage

// ===== rtl/asr_front.sv
// line front end: pin synchroniser and 16x base-tick generator
`timescale 1ns/1ns
`default_nettype none
module asr_front #(
  parameter int DIV_W = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic rxd_pin,
  input wire logic [DIV_W-1:0] divisor,
  output asr_pkg::asr_line_t line
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic tick;
    logic [DIV_W-1:0] cnt;
  } asr_front_state_t;

  asr_front_state_t s_reg;
  asr_front_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    // sync1 feeds sync2 only
    s_next.sync1 = rxd_pin;
    s_next.sync2 = s_reg.sync1;
    s_next.tick = 1'b0;
    if (s_reg.cnt == '0)
    begin
      s_next.cnt = divisor;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // idle line is high
      s_reg <= '{sync1: 1'b1, sync2: 1'b1, tick: 1'b0, cnt: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign line.level = s_reg.sync2;
  assign line.tick = s_reg.tick;

endmodule // asr_front
`default_nettype wire

// ===== rtl/asr_top.sv
// asynchronous serial receiver with multiprocessor addressing and an axi4-lite register slave
//
// Functional notes
// - detect start, shift frame, check parity, stop
// - frame while full: overrun, data lost
// - any error flag with enable raises error_irq
// - parity mismatch flags and still stores data
// - zero stop bit flags and stores data
// - clean frame stores data, sets full flag
// - errored frame leaves full flag unchanged
// - no new frame while error flag set
// - dma data read clears full flag
// - address bit one is id, zero data
// - id wait skips frames until address bit
// - address frame sets flag, ends id wait
// - address format ignores parity enable
// - transmit address bit chosen by software
// - 16x base clock, latch on 8th tick
// - twelve formats: 7/8 data, parity/address, stops
`timescale 1ns/1ns
`default_nettype none
module asr_top #(
  parameter int ADDR_W = 4,
  parameter int DIV_W = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_pin,
  input wire logic dma_read_strobe,
  output logic [7:0] rx_data,
  output logic receive_full_irq,
  output logic error_irq
);

  typedef struct packed {
    // register bus
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // registers
    asr_pkg::asr_ctrl_t ctrl;
    logic [DIV_W-1:0] divisor;
    logic [7:0] receive_data_reg;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_fault_flag;
    logic parity_fault_flag;
    logic received_address_bit;
    logic receive_full_irq;
    logic error_irq;
    // receiver
    asr_pkg::asr_rx_state_t rx_state;
    logic [3:0] tick_cnt;
    logic [2:0] bit_idx;
    logic [7:0] receive_shift_reg;
    logic extra_bit;
    logic line_prev;
  } asr_state_t;

  asr_state_t s_reg;
  asr_state_t s_next;
  asr_pkg::asr_line_t line;

  asr_front #(
    .DIV_W(DIV_W)
  ) u_front (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .rxd_pin(rxd_pin),
    .divisor(s_reg.divisor),
    .line(line)
  );

  function automatic logic [31:0] read_mux(input asr_state_t s, input logic [ADDR_W-1:0] a,
                                           input logic lvl);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      asr_pkg::OFS_CTRL: v[8:0] = s.ctrl;
      asr_pkg::OFS_STATUS:
      begin
        v[asr_pkg::STS_FULL] = s.rx_full_flag;
        v[asr_pkg::STS_OVR] = s.overrun_flag;
        v[asr_pkg::STS_FER] = s.framing_fault_flag;
        v[asr_pkg::STS_PER] = s.parity_fault_flag;
        v[asr_pkg::STS_ADDR_BIT] = s.received_address_bit;
        v[asr_pkg::STS_LINE] = lvl;
      end
      asr_pkg::OFS_DATA: v[7:0] = s.receive_data_reg;
      asr_pkg::OFS_BAUD: v[DIV_W-1:0] = s.divisor;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == asr_pkg::OFS_CTRL) || (a == asr_pkg::OFS_STATUS) ||
           (a == asr_pkg::OFS_DATA) || (a == asr_pkg::OFS_BAUD);
  endfunction

  always_comb
  begin
    logic has_extra;
    logic par_bad;
    logic stop_bad;
    logic any_err;
    logic [7:0] frame_data;
    logic [2:0] last_bit;
    has_extra = 1'b0;
    par_bad = 1'b0;
    stop_bad = 1'b0;
    any_err = 1'b0;
    frame_data = 8'h00;
    last_bit = 3'h0;
    s_next = s_reg;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
    begin
      s_next.bvalid = 1'b0;
    end
    if (s_next.aw_got && s_next.w_got && !s_next.bvalid)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_next.aw_addr) ? asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
      unique case (s_next.aw_addr)
        asr_pkg::OFS_CTRL:
        begin
          if (s_next.w_strb[0])
          begin
            s_next.ctrl[7:0] = s_next.w_data[7:0];
          end
          if (s_next.w_strb[1])
          begin
            s_next.ctrl.tx_address_bit = s_next.w_data[asr_pkg::CTL_TX_ADDR];
          end
        end
        asr_pkg::OFS_STATUS:
        begin
          // writing zero clears a flag; later frame events override
          if (s_next.w_strb[0])
          begin
            if (!s_next.w_data[asr_pkg::STS_FULL])
            begin
              s_next.rx_full_flag = 1'b0;
            end
            if (!s_next.w_data[asr_pkg::STS_OVR])
            begin
              s_next.overrun_flag = 1'b0;
            end
            if (!s_next.w_data[asr_pkg::STS_FER])
            begin
              s_next.framing_fault_flag = 1'b0;
            end
            if (!s_next.w_data[asr_pkg::STS_PER])
            begin
              s_next.parity_fault_flag = 1'b0;
            end
            if (!s_next.w_data[asr_pkg::STS_ADDR_BIT])
            begin
              s_next.received_address_bit = 1'b0;
            end
          end
        end
        asr_pkg::OFS_BAUD:
        begin
          if (s_next.w_strb[0])
          begin
            s_next.divisor[7:0] = s_next.w_data[7:0];
          end
          if (s_next.w_strb[1])
          begin
            s_next.divisor[DIV_W-1:8] = s_next.w_data[DIV_W-1:8];
          end
        end
        default:
        begin
        end
      endcase
    end

    // read channel
    if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = read_mux(s_reg, s_axi_araddr, line.level);
      s_next.rresp = mapped(s_axi_araddr) ? asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
    end

    if (dma_read_strobe)
    begin
      s_next.rx_full_flag = 1'b0;
    end

    // receiver
    has_extra = s_reg.ctrl.address_bit_format || s_reg.ctrl.parity_enable;
    last_bit = s_reg.ctrl.seven_bit_select ? asr_pkg::BITS_7_LAST : asr_pkg::BITS_8_LAST;
    any_err = s_reg.overrun_flag || s_reg.framing_fault_flag || s_reg.parity_fault_flag;
    if (line.tick)
    begin
      s_next.line_prev = line.level;
      s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
    end
    unique case (s_reg.rx_state)
      asr_pkg::RX_IDLE:
      begin
        s_next.tick_cnt = 4'h0;
        // falling edge only, so a held break never retriggers
        if (line.tick && s_reg.line_prev && !line.level && s_reg.ctrl.rx_enable && !any_err)
        begin
          s_next.rx_state = asr_pkg::RX_START;
        end
      end
      asr_pkg::RX_START:
      begin
        if (line.tick && s_reg.tick_cnt == asr_pkg::MID_START)
        begin
          // 8th tick after the edge is mid start bit; a high level is a glitch
          s_next.tick_cnt = 4'h0;
          s_next.bit_idx = 3'h0;
          s_next.rx_state = line.level ? asr_pkg::RX_IDLE : asr_pkg::RX_DATA;
        end
      end
      asr_pkg::RX_DATA:
      begin
        if (line.tick && s_reg.tick_cnt == asr_pkg::TICKS_LAST)
        begin
          s_next.receive_shift_reg = {line.level, s_reg.receive_shift_reg[7:1]};
          s_next.bit_idx = s_reg.bit_idx + 3'h1;
          if (s_reg.bit_idx == last_bit)
          begin
            s_next.rx_state = has_extra ? asr_pkg::RX_EXTRA : asr_pkg::RX_STOP;
          end
        end
      end
      asr_pkg::RX_EXTRA:
      begin
        if (line.tick && s_reg.tick_cnt == asr_pkg::TICKS_LAST)
        begin
          s_next.extra_bit = line.level;
          s_next.rx_state = asr_pkg::RX_STOP;
        end
      end
      asr_pkg::RX_STOP:
      begin
        if (line.tick && s_reg.tick_cnt == asr_pkg::TICKS_LAST)
        begin
          // frame ends at mid first stop; a second stop bit is just idle line
          s_next.rx_state = asr_pkg::RX_IDLE;
          frame_data = s_reg.ctrl.seven_bit_select ?
                       {1'b0, s_reg.receive_shift_reg[7:1]} : s_reg.receive_shift_reg;
          par_bad = s_reg.ctrl.parity_enable && !s_reg.ctrl.address_bit_format &&
                    ((^{frame_data, s_reg.extra_bit}) != s_reg.ctrl.parity_odd);
          stop_bad = !line.level;
          if (s_reg.ctrl.address_bit_format)
          begin
            s_next.received_address_bit = s_reg.extra_bit;
          end
          if (s_reg.ctrl.address_bit_format && s_reg.ctrl.id_wait_enable && !s_reg.extra_bit)
          begin
            // data frame for another station: skipped silently
            s_next.rx_state = asr_pkg::RX_IDLE;
          end
          else
          begin
            if (s_reg.ctrl.address_bit_format && s_reg.ctrl.id_wait_enable)
            begin
              s_next.ctrl.id_wait_enable = 1'b0;
            end
            s_next.framing_fault_flag = s_next.framing_fault_flag || stop_bad;
            s_next.parity_fault_flag = s_next.parity_fault_flag || par_bad;
            if (s_reg.rx_full_flag)
            begin
              // data lost, full flag kept
              s_next.overrun_flag = 1'b1;
              s_next.rx_full_flag = 1'b1;
            end
            else if (stop_bad || par_bad)
            begin
              s_next.receive_data_reg = frame_data;
              s_next.rx_full_flag = s_reg.rx_full_flag;
            end
            else
            begin
              s_next.receive_data_reg = frame_data;
              s_next.rx_full_flag = 1'b1;
            end
          end
        end
      end
    endcase
    if (!s_reg.ctrl.rx_enable)
    begin
      // disabling aborts a frame but keeps flags and data
      s_next.rx_state = asr_pkg::RX_IDLE;
    end

    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
    s_next.receive_full_irq = s_next.rx_full_flag && s_next.ctrl.receive_irq_enable;
    s_next.error_irq = (s_next.overrun_flag || s_next.framing_fault_flag ||
                        s_next.parity_fault_flag) && s_next.ctrl.receive_irq_enable;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.divisor <= DIV_W'(asr_pkg::BAUD_RESET);
      s_reg.line_prev <= 1'b1;
      s_reg.rx_state <= asr_pkg::RX_IDLE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign rx_data = s_reg.receive_data_reg;
  assign receive_full_irq = s_reg.receive_full_irq;
  assign error_irq = s_reg.error_irq;

endmodule // asr_top
`default_nettype wire

// ===== testbench/asr_props.sv
// checker: bus handshake and receive-flag properties of the serial receiver
`timescale 1ns/1ns
`default_nettype none
module asr_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dma_read_strobe,
  input wire logic [7:0] rx_data,
  input wire logic receive_full_irq,
  input wire logic error_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_WR_RESP:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  AST_B_HOLD:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_DONE:
  assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready)
    else $error("write channel not reopened");
  AST_RD_RESP:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response missing");
  AST_R_HOLD:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // data register frozen while an error flag blocks reception
  AST_ERR_FREEZE:
  assert property (error_irq |=> $stable(rx_data))
    else $error("data changed under error");
  AST_ERR_NOT_FULL:
  assert property ($rose(error_irq) |-> !$rose(receive_full_irq))
    else $error("full set by errored frame");
  // an overrun in the same cycle may keep full, so error_irq excuses it
  AST_DMA_CLR:
  assert property (dma_read_strobe && receive_full_irq && !error_irq
    |=> ##1 (!receive_full_irq || error_irq))
    else $error("dma read left full set");
endmodule // asr_props
`default_nettype wire

// ===== testbench/asr_station.sv
// partner model: remote station driving frames onto the shared line
`timescale 1ns/1ns
`default_nettype none
module asr_station #(
  parameter int BIT_CLKS = 16
) (
  input wire logic ref_clk,
  output var logic rxd
);
  initial rxd = 1'b1;
  // gap idle bits first, so the station can be prompt or slow
  task automatic send(input logic [7:0] d, input int nb, input logic xe, input logic xb,
                      input logic sb, input int gap);
    logic [11:0] f;
    int n;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++)
      f[1 + i] = d[i];
    n = nb + 1;
    if (xe)
    begin
      f[n] = xb;
      n++;
    end
    f[n] = sb;
    repeat (gap * BIT_CLKS) @(posedge ref_clk);
    for (int i = 0; i <= n; i++)
    begin
      @(posedge ref_clk);
      rxd <= f[i];
      repeat (BIT_CLKS - 1) @(posedge ref_clk);
    end
    // back to mark level: a broken stop bit must not linger
    @(posedge ref_clk);
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask
endmodule // asr_station
`default_nettype wire

// ===== testbench/asr_top_tb.sv
// testbench: register-bus and serial-line scenarios for the serial receiver
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got %0h exp %0h", $time, (g), (e)); end end
module asr_top_tb;
  logic ref_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rxd, dma, full_irq, err_irq;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] rx_data;
  int bad_count, num_checks, cycles;
  // status line bit reads high while the line idles
  localparam logic [31:0] IDLE = 32'h00000020;
  localparam logic [3:0] ST = asr_pkg::OFS_STATUS;
  localparam logic [3:0] CT = asr_pkg::OFS_CTRL;
  asr_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd_pin(rxd),
    .dma_read_strobe(dma), .rx_data(rx_data), .receive_full_irq(full_irq),
    .error_irq(err_irq));
  asr_station #(.BIT_CLKS(16)) station_u (.ref_clk(ref_clk), .rxd(rxd));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  // handshakes judged at the negedge, released at the following posedge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(negedge ref_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge ref_clk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
      if (hb)
      begin
        bready <= 1'b0;
        break;
      end
    end
    `CHK(r, asr_pkg::RESP_OKAY)
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] rr;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(negedge ref_clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      rr = rresp;
      @(posedge ref_clk);
      if (ha)
        arvalid <= 1'b0;
      if (hr)
      begin
        rready <= 1'b0;
        break;
      end
    end
    `CHK(d, e)
    `CHK(rr, asr_pkg::RESP_OKAY)
  endtask
  initial
  begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, dma} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    chk_rd(CT, 32'h0);
    chk_rd(asr_pkg::OFS_BAUD, {16'h0, asr_pkg::BAUD_RESET});
    wr(asr_pkg::OFS_BAUD, 32'h0);
    // old divisor count must run out before the fast tick starts
    repeat (200) @(posedge ref_clk);
    wr(CT, 32'h3);
    station_u.send(8'hA5, 8, 0, 0, 1, 2);
    `CHK(rx_data, 8'hA5)
    `CHK(full_irq, 1'b1)
    chk_rd(ST, IDLE | 32'h1);
    chk_rd(asr_pkg::OFS_DATA, 32'hA5);
    @(posedge ref_clk);
    dma <= 1'b1;
    @(posedge ref_clk);
    dma <= 1'b0;
    chk_rd(ST, IDLE);
    `CHK(full_irq, 1'b0)
    station_u.send(8'h11, 8, 0, 0, 1, 1);
    station_u.send(8'h22, 8, 0, 0, 1, 0);
    `CHK(rx_data, 8'h11)
    chk_rd(ST, IDLE | 32'h3);
    `CHK(err_irq, 1'b1)
    station_u.send(8'h33, 8, 0, 0, 0, 0);
    chk_rd(ST, IDLE | 32'h3);
    `CHK(rx_data, 8'h11)
    wr(ST, 32'h0);
    wr(CT, 32'h13);
    station_u.send(8'h5A, 8, 1, 1, 1, 1);
    chk_rd(ST, IDLE | 32'h8);
    `CHK(rx_data, 8'h5A)
    `CHK(full_irq, 1'b0)
    `CHK(err_irq, 1'b1)
    wr(ST, 32'h0);
    station_u.send(8'h3C, 8, 1, 0, 0, 1);
    chk_rd(ST, IDLE | 32'h4);
    `CHK(rx_data, 8'h3C)
    wr(ST, 32'h0);
    wr(CT, 32'hB);
    station_u.send(8'hD5, 7, 0, 0, 1, 1);
    `CHK(rx_data, 8'h55)
    wr(ST, 32'h0);
    // parity enable left set: address format must ignore it
    wr(CT, 32'h57);
    station_u.send(8'h66, 8, 1, 0, 1, 1);
    chk_rd(ST, IDLE);
    `CHK(rx_data, 8'h55)
    station_u.send(8'h42, 8, 1, 1, 1, 1);
    `CHK(rx_data, 8'h42)
    chk_rd(ST, IDLE | 32'h11);
    chk_rd(CT, 32'h53);
    wr(ST, 32'h0);
    // odd data weight: a parity check here would flag it
    station_u.send(8'h76, 8, 1, 0, 1, 1);
    `CHK(rx_data, 8'h76)
    chk_rd(ST, IDLE | 32'h1);
    wr(ST, 32'h0);
    wr(CT, 32'h57);
    station_u.send(8'h99, 8, 1, 0, 1, 1);
    chk_rd(ST, IDLE);
    `CHK(rx_data, 8'h76)
    wrap_up();
  end
endmodule // asr_top_tb
bind asr_top asr_props props_u (.ref_clk(ref_clk), .nrst(nrst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .dma_read_strobe(dma_read_strobe), .rx_data(rx_data),
  .receive_full_irq(receive_full_irq), .error_irq(error_irq));
`default_nettype wire
